// [hw/etc_map.svh]
`ifndef ETC_MAP_SVH
`define ETC_MAP_SVH
// Register byte offsets on the AXI4-Lite bus.
`define ETC_CTRL_OFS 8'h00
`define ETC_STAT_OFS 8'h04
`define ETC_MASK_OFS 8'h08
`define ETC_CYC_OFS 8'h0c
`define ETC_TIDX_OFS 8'h10
`define ETC_PSEL_OFS 8'h14
`define ETC_RIDX_OFS 8'h18
`define ETC_RDAT0_OFS 8'h1c
`define ETC_RDAT1_OFS 8'h20
`define ETC_RDAT2_OFS 8'h24
// Control register bit positions.
`define ETC_CTRL_RUN 0
`define ETC_CTRL_CBRK_EN 1
`define ETC_CTRL_TBRK_EN 2
`define ETC_CTRL_TRACE_EN 3
`define ETC_CTRL_CLR_TIDX 4
`define ETC_CTRL_START 5
`define ETC_CTRL_EVA_RST 6
// Status and mask bit positions.
`define ETC_ST_COVF 0
`define ETC_ST_TOVF 1
// Reset values.
`define ETC_CTRL_RST 32'h0000_0000
`define ETC_PSEL_RST 32'h0000_0010
// Width of one trace memory word; the packed entry fills its low bits.
`define ETC_ENTRY_W 96
`endif

// [hw/etc_mem.sv]
`timescale 1ns/1ps
// Simple trace memory with one write port and a registered read port.
module etc_mem #(
   parameter int DEPTH = 8192,
   parameter int AW = 13,
   parameter int W = 96
) (
   // Clock and enable.
   input wire logic clk,
   input wire logic ce,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [W-1:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [W-1:0] rdata
);
   // Storage array.
   logic [W-1:0] mem_r [DEPTH];
   // Write and registered read, both frozen when the enable is low.
   always_ff @(posedge clk) begin
      if (ce) begin
         if (we) begin
            mem_r[waddr] <= wdata;
         end
         rdata <= mem_r[raddr];
      end
   end
endmodule : etc_mem

// [hw/etc_pkg.sv]
package etc_pkg;
   // State of the target core captured on each instruction strobe while tracing.
   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] ram_addr;
      logic [3:0] ram_data;
      logic carry;
      logic mie;
      logic irq_xfer;
      logic skip;
      logic [23:0] regs;
      logic [7:0] sp;
      logic [3:0] port_a;
      logic [3:0] port_b;
   } etc_core_type;
   // All five port data values offered by the core.
   typedef struct packed {
      logic [4:0][3:0] val;
   } etc_ports_type;
   // AXI4-Lite slave side state.
   typedef enum logic [2:0] {
      BUS_IDLE = 3'b001,
      BUS_WRESP = 3'b010,
      BUS_RDATA = 3'b100
   } etc_bus_type;
endpackage : etc_pkg

// [hw/etc_top.sv]
`timescale 1ns/1ps
`include "etc_map.svh"
module etc_top #(
   parameter int DEPTH = 8192,
   parameter int AW = 13
) (
   // Clock, reset and clock enable.
   input wire logic CLOCK,
   input wire logic SRST,
   input wire logic CE,
   // AXI4-Lite write address and data.
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   // AXI4-Lite write response.
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   // AXI4-Lite read.
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Evaluation core, same clock: machine cycle strobe and state.
   input wire logic MC_STB,
   input wire logic INSN_STB,
   input wire etc_pkg::etc_core_type CORE_STATE,
   input wire etc_pkg::etc_ports_type CORE_PORTS,
   // Control outputs to the core and the emulator.
   output logic EVA_RESET,
   output logic BREAK_REQ,
   output logic IRQ
);
   // Whole module state in one packed struct.
   typedef struct packed {
      etc_pkg::etc_bus_type bus;
      logic awready;
      logic wready;
      logic arready;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [7:0] araddr;
      logic [1:0] bresp;
      logic bvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic rvalid;
      logic rd_wait;
      logic [31:0] ctrl;
      logic [1:0] stat;
      logic [1:0] mask;
      logic [31:0] cyc;
      logic [AW-1:0] tidx;
      logic [5:0] psel;
      logic [AW-1:0] ridx;
      logic eva_rst;
      logic brk;
      logic irq;
   } etc_state_type;

   etc_state_type s_r;
   etc_state_type s_nxt;

   // Trace memory interface.
   logic mem_we;
   logic [`ETC_ENTRY_W-1:0] mem_wdata;
   logic [`ETC_ENTRY_W-1:0] mem_rdata;
   etc_pkg::etc_core_type entry;

   // Pick one port value by its 3-bit select; unused codes read zero.
   function automatic logic [3:0] pick_port(input etc_pkg::etc_ports_type p,
                                            input logic [2:0] sel);
      logic [3:0] v;
      v = 4'h0;
      if (sel < 3'h5) begin
         v = p.val[sel];
      end
      return v;
   endfunction : pick_port

   // Byte-lane merge of a write into a base word; the write path passes zero as the base.
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction : merge

   // Build the trace entry from core state and the selected two ports.
   always_comb begin
      entry = CORE_STATE;
      entry.port_a = pick_port(CORE_PORTS, s_r.psel[2:0]);
      entry.port_b = pick_port(CORE_PORTS, s_r.psel[5:3]);
      mem_wdata = '0; // Bits above the entry are spare and read back as zero.
      mem_wdata[$bits(etc_pkg::etc_core_type)-1:0] = entry;
      mem_we = CE && !s_r.eva_rst && s_r.ctrl[`ETC_CTRL_TRACE_EN] && INSN_STB;
   end

   // Next-state logic for bus, counter, trace index and flags.
   always_comb begin
      logic wr_fire;
      logic [31:0] wd;
      logic [7:0] wa;
      logic cyc_wrap;
      logic trc_wrap;
      logic clr_idx;
      logic [31:0] rd;
      wr_fire = 1'b0;
      wd = 32'h0;
      wa = 8'h0;
      cyc_wrap = 1'b0;
      trc_wrap = 1'b0;
      clr_idx = 1'b0;
      rd = 32'h0;
      s_nxt = s_r;
      // Self-clearing command bits and the reset pulse.
      s_nxt.ctrl[`ETC_CTRL_CLR_TIDX] = 1'b0;
      s_nxt.ctrl[`ETC_CTRL_START] = 1'b0;
      s_nxt.ctrl[`ETC_CTRL_EVA_RST] = 1'b0;
      s_nxt.eva_rst = s_r.ctrl[`ETC_CTRL_EVA_RST];
      // Write channels are taken independently, in either order.
      if (s_r.awready && AWVALID) begin
         s_nxt.awready = 1'b0;
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = AWADDR;
      end
      if (s_r.wready && WVALID) begin
         s_nxt.wready = 1'b0;
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = merge(32'h0, WDATA, WSTRB);
      end
      // Both halves present: perform the write and raise the response.
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         wr_fire = 1'b1;
         wd = s_r.wdata;
         wa = s_r.awaddr;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = 2'h0;
      end
      if (s_r.bvalid && BREADY) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.awready = 1'b1;
         s_nxt.wready = 1'b1;
      end
      // Read address accepted, data answered one cycle later.
      if (s_r.arready && ARVALID) begin
         s_nxt.arready = 1'b0;
         s_nxt.araddr = ARADDR;
         s_nxt.rd_wait = 1'b1;
      end
      if (s_r.rd_wait) begin
         s_nxt.rd_wait = 1'b0;
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = 2'h0;
         case ({s_r.araddr[7:2], 2'b00})
            `ETC_CTRL_OFS: rd = s_r.ctrl;
            `ETC_STAT_OFS: rd = {30'h0, s_r.stat};
            `ETC_MASK_OFS: rd = {30'h0, s_r.mask};
            `ETC_CYC_OFS: rd = s_r.cyc;
            `ETC_TIDX_OFS: rd = {{(32-AW){1'b0}}, s_r.tidx};
            `ETC_PSEL_OFS: rd = {26'h0, s_r.psel};
            `ETC_RIDX_OFS: rd = {{(32-AW){1'b0}}, s_r.ridx};
            `ETC_RDAT0_OFS: rd = mem_rdata[31:0];
            `ETC_RDAT1_OFS: rd = mem_rdata[63:32];
            `ETC_RDAT2_OFS: rd = mem_rdata[95:64];
            default: s_nxt.rresp = 2'h2;
         endcase
         s_nxt.rdata = rd;
      end
      if (s_r.rvalid && RREADY) begin
         s_nxt.rvalid = 1'b0;
         s_nxt.arready = 1'b1;
      end
      // Bus summary code: the write answer is reported ahead of a read answer.
      case (s_r.bus)
         etc_pkg::BUS_IDLE, etc_pkg::BUS_WRESP, etc_pkg::BUS_RDATA: begin
            if (s_nxt.bvalid) begin
               s_nxt.bus = etc_pkg::BUS_WRESP;
            end else if (s_nxt.rvalid) begin
               s_nxt.bus = etc_pkg::BUS_RDATA;
            end else begin
               s_nxt.bus = etc_pkg::BUS_IDLE;
            end
         end
         // An illegal code falls back to idle.
         default: s_nxt.bus = etc_pkg::BUS_IDLE;
      endcase
      // Cycle counter advances once per machine cycle while running.
      if (s_r.ctrl[`ETC_CTRL_RUN] && MC_STB && !s_r.eva_rst) begin
         s_nxt.cyc = s_r.cyc + 32'h1;
         cyc_wrap = (s_r.cyc == 32'hffff_ffff);
      end
      // Trace index steps once per recorded entry; wrap flags overflow.
      if (mem_we) begin
         s_nxt.tidx = s_r.tidx + AW'(1);
         trc_wrap = (s_r.tidx == AW'(DEPTH - 1));
      end
      // Register writes: load, configure and command bits.
      if (wr_fire) begin
         case (wa)
            `ETC_CTRL_OFS: begin
               s_nxt.ctrl = wd;
               clr_idx = wd[`ETC_CTRL_CLR_TIDX] || wd[`ETC_CTRL_START];
            end
            `ETC_STAT_OFS: s_nxt.stat = s_r.stat & ~wd[1:0];
            `ETC_MASK_OFS: s_nxt.mask = wd[1:0];
            `ETC_CYC_OFS: s_nxt.cyc = wd;
            `ETC_PSEL_OFS: begin
               s_nxt.psel = wd[5:0];
               clr_idx = 1'b1;
            end
            `ETC_RIDX_OFS: s_nxt.ridx = wd[AW-1:0];
            default: ;
         endcase
      end
      if (clr_idx) begin
         s_nxt.tidx = '0;
         s_nxt.stat[`ETC_ST_TOVF] = 1'b0;
      end
      // Hardware sets win over software clears.
      if (cyc_wrap) begin
         s_nxt.stat[`ETC_ST_COVF] = 1'b1;
      end
      if (trc_wrap) begin
         s_nxt.tidx = '0;
         s_nxt.stat[`ETC_ST_TOVF] = 1'b1;
      end
      // Break request on enabled overflow events, held until a control write clears run.
      // A software stop is applied first, so an event in the same cycle wins.
      if (wr_fire && wa == `ETC_CTRL_OFS && !wd[`ETC_CTRL_RUN]) begin
         s_nxt.brk = 1'b0;
      end
      if (cyc_wrap && s_r.ctrl[`ETC_CTRL_CBRK_EN]) begin
         s_nxt.brk = 1'b1;
      end
      if (trc_wrap && s_r.ctrl[`ETC_CTRL_TBRK_EN]) begin
         s_nxt.brk = 1'b1;
      end
      if (s_nxt.brk) begin
         s_nxt.ctrl[`ETC_CTRL_RUN] = 1'b0;
      end
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         s_r <= '0;
         s_r.bus <= etc_pkg::BUS_IDLE;
         s_r.awready <= 1'b1;
         s_r.wready <= 1'b1;
         s_r.arready <= 1'b1;
         s_r.ctrl <= `ETC_CTRL_RST;
         s_r.psel <= 6'(`ETC_PSEL_RST);
      end else if (CE) begin
         s_r <= s_nxt;
      end
   end

   // Trace memory instance.
   etc_mem #(.DEPTH(DEPTH), .AW(AW), .W(`ETC_ENTRY_W)) u_mem (
      .clk(CLOCK),
      .ce(CE),
      .we(mem_we),
      .waddr(s_r.tidx),
      .wdata(mem_wdata),
      .raddr(s_r.ridx),
      .rdata(mem_rdata)
   );

   // Outputs straight from the state register.
   assign AWREADY = s_r.awready;
   assign WREADY = s_r.wready;
   assign BRESP = s_r.bresp;
   assign BVALID = s_r.bvalid;
   assign ARREADY = s_r.arready;
   assign RDATA = s_r.rdata;
   assign RRESP = s_r.rresp;
   assign RVALID = s_r.rvalid;
   assign EVA_RESET = s_r.eva_rst;
   assign BREAK_REQ = s_r.brk;
   assign IRQ = s_r.irq;

   // Counter wraps to zero and sets its flag one cycle later.
   counter_wrap_a: assert property (@(posedge CLOCK) disable iff (SRST)
      CE && s_r.ctrl[0] && MC_STB && !s_r.eva_rst && s_r.cyc == 32'hffff_ffff
      && !(s_r.bvalid == 1'b0 && s_r.aw_got && s_r.w_got)
      |=> s_r.cyc == 32'h0 && s_r.stat[0]) else $error("counter wrap missed");
   counter_step_a: assert property (@(posedge CLOCK) disable iff (SRST)
      CE && s_r.ctrl[0] && MC_STB && !s_r.eva_rst && !(s_r.bvalid == 1'b0 && s_r.aw_got
      && s_r.w_got) |=> s_r.cyc == $past(s_r.cyc) + 32'h1) else $error("counter step");
   trace_step_a: assert property (@(posedge CLOCK) disable iff (SRST)
      mem_we && s_r.tidx != AW'(DEPTH - 1) && !(s_r.aw_got && s_r.w_got)
      |=> s_r.tidx == $past(s_r.tidx) + AW'(1)) else $error("trace index step");
   trace_wrap_a: assert property (@(posedge CLOCK) disable iff (SRST)
      mem_we && s_r.tidx == AW'(DEPTH - 1) |=> s_r.tidx == '0 && s_r.stat[1])
      else $error("trace wrap");
   trace_break_a: assert property (@(posedge CLOCK) disable iff (SRST)
      mem_we && s_r.tidx == AW'(DEPTH - 1) && s_r.ctrl[2] |=> BREAK_REQ)
      else $error("trace break");
   count_break_a: assert property (@(posedge CLOCK) disable iff (SRST)
      CE && s_r.ctrl[0] && s_r.ctrl[1] && MC_STB && !s_r.eva_rst
      && s_r.cyc == 32'hffff_ffff |=> BREAK_REQ && !s_r.ctrl[0])
      else $error("count break");
   eva_reset_a: assert property (@(posedge CLOCK) disable iff (SRST)
      CE && s_r.ctrl[6] |=> EVA_RESET) else $error("eval reset pulse");
   // The interrupt line always agrees with the status and mask it summarises.
   irq_level_a: assert property (@(posedge CLOCK) disable iff (SRST)
      IRQ == |(s_r.stat & s_r.mask)) else $error("irq level");
   // Bus summary state never holds more or less than one code.
   bus_onehot_a: assert property (@(posedge CLOCK) disable iff (SRST)
      $onehot(s_r.bus)) else $error("bus state code");
   // Both write halves held while no answer is pending: the write happens now.
   sequence wr_both_s;
      CE && s_r.aw_got && s_r.w_got && !s_r.bvalid;
   endsequence
   // A write to one register offset is being performed.
   sequence wr_to_s(logic [7:0] ofs);
      wr_both_s ##0 s_r.awaddr == ofs;
   endsequence
   // A read address taken, followed by an enabled cycle for the lookup.
   sequence rd_taken_s;
      CE && ARVALID && ARREADY ##1 CE;
   endsequence
   // Bus answers come at the cycle the handshake walk promises.
   write_answer_a: assert property (@(posedge CLOCK) disable iff (SRST)
      wr_both_s |=> BVALID) else $error("write answer missing");
   read_answer_a: assert property (@(posedge CLOCK) disable iff (SRST)
      rd_taken_s |=> RVALID) else $error("read answer missing");
   count_load_a: assert property (@(posedge CLOCK) disable iff (SRST)
      wr_to_s(`ETC_CYC_OFS) |=> s_r.cyc == $past(s_r.wdata)) else $error("counter load");
   index_clear_a: assert property (@(posedge CLOCK) disable iff (SRST)
      wr_to_s(`ETC_CTRL_OFS) ##0 (s_r.wdata[4] && !(mem_we && s_r.tidx == AW'(DEPTH - 1)))
      |=> s_r.tidx == '0 && !s_r.stat[1]) else $error("index clear");
endmodule : etc_top

// [verif/etc_core_model.sv]
`timescale 1ns/1ps
// Stand-in for the evaluation core: bursts of machine cycles on request.
module etc_core_model (
   // Clock and core reset request.
   input wire logic clk,
   input wire logic eva_reset,
   // Burst request from the bench.
   input wire logic go,
   input wire logic [7:0] n,
   // Core side outputs.
   output logic mc_stb,
   output logic insn_stb,
   output etc_pkg::etc_core_type state,
   output etc_pkg::etc_ports_type ports,
   output logic busy,
   output logic [7:0] resets
);
   // Half-cycles left in the burst; a strobe falls on every odd count.
   logic [8:0] left = 9'h000;
   logic [127:0] rnd;
   initial begin
      mc_stb = 1'b0;
      insn_stb = 1'b0;
      resets = 8'h00;
   end
   assign busy = (left != 9'h000) || mc_stb;
   // State changes every cycle so that a stale sample never passes.
   always @(posedge clk) begin
      rnd = {$urandom, $urandom, $urandom, $urandom};
      {state, ports} <= rnd[99:0];
      if (eva_reset) begin
         resets <= resets + 8'h01;
         left <= 9'h000;
         mc_stb <= 1'b0;
         insn_stb <= 1'b0;
      end else if (go) begin
         left <= {n, 1'b0};
      end else begin
         left <= (left != 9'h000) ? left - 9'h001 : left;
         mc_stb <= left[0];
         insn_stb <= left[0];
      end
   end
endmodule : etc_core_model

// [verif/test_emulator_trace_cycle_counter.sv]
`timescale 1ns/1ps
`include "etc_map.svh"
// Compares a value with its expectation and counts the outcome.
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module test_emulator_trace_cycle_counter;
   // Clock, reset and bus master signals.
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rd_d;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, eva_reset, break_req, irq;
   logic [1:0] bresp, rresp, rd_r;
   // Core model signals and the samples it offered.
   logic go = 1'b0;
   logic [7:0] n = 8'h00, resets, rs;
   logic mc_stb, insn_stb, busy;
   etc_pkg::etc_core_type st;
   etc_pkg::etc_ports_type pt;
   logic [99:0] hist[$];
   int bad_count = 0;
   int check_count = 0;
   always #4 clk = ~clk;
   etc_top #(.DEPTH(16), .AW(4)) u_dut (.CLOCK(clk), .SRST(srst), .CE(ce),
      .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata),
      .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready), .MC_STB(mc_stb), .INSN_STB(insn_stb), .CORE_STATE(st),
      .CORE_PORTS(pt), .EVA_RESET(eva_reset), .BREAK_REQ(break_req), .IRQ(irq));
   etc_core_model u_core (.clk(clk), .eva_reset(eva_reset), .go(go), .n(n),
      .mc_stb(mc_stb), .insn_stb(insn_stb), .state(st), .ports(pt),
      .busy(busy), .resets(resets));
   // Keeps every sample the core offered with an entry strobe.
   always @(posedge clk) if (insn_stb) hist.push_back({st, pt});
   // One write; address and data are each released when taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int t;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end while (!bvalid && t < 50);
      `CHK(bvalid, 1'b1)
      `CHK(bresp, 2'b00)
      bready <= 1'b0;
   endtask : wr
   // One read; data and response are taken at the answering edge.
   task automatic rd(input logic [7:0] a);
      int t;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      t = 0;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         t++;
      end while (!rvalid && t < 50);
      `CHK(rvalid, 1'b1)
      rd_d = rdata;
      rd_r = rresp;
      rready <= 1'b0;
   endtask : rd
   // Asks the core for k machine cycles and waits until they are over.
   task automatic burst(input logic [7:0] k);
      int t;
      @(posedge clk);
      n <= k;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      @(posedge clk);
      t = 0;
      while (busy && t < 600) begin
         @(posedge clk);
         t++;
      end
      `CHK(busy, 1'b0)
   endtask : burst
   // Entry expected for one sample, with the two chosen ports put in.
   function automatic logic [79:0] ent(input logic [99:0] h, input logic [2:0] a, b);
      etc_pkg::etc_core_type c;
      etc_pkg::etc_ports_type p;
      {c, p} = h;
      c.port_a = p.val[a];
      c.port_b = p.val[b];
      return c;
   endfunction : ent
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : close_out
   // Cuts a hang short.
   initial begin
      #200000;
      bad_count++;
      close_out();
   end
   // Main sequence.
   initial begin
      logic [31:0] v;
      logic [32:0] s;
      logic [95:0] e;
      logic [2:0] sb;
      int r;
      void'($urandom(32'hd7326316));
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      // Reset values, then an unmapped read that must be refused.
      rd(`ETC_PSEL_OFS);
      `CHK(rd_d, `ETC_PSEL_RST)
      rd(`ETC_TIDX_OFS);
      `CHK(rd_d, 32'h0)
      rd(8'h28);
      `CHK(rd_r, 2'b10)
      // Loaded counts advance once per machine cycle, wrap included.
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 32'hffff_fffe : $urandom;
         r = $urandom_range(20, 1);
         s = {1'b0, v} + 33'(r);
         wr(`ETC_STAT_OFS, 32'h3);
         wr(`ETC_CYC_OFS, v);
         wr(`ETC_CTRL_OFS, 32'h1);
         burst(8'(r));
         wr(`ETC_CTRL_OFS, 32'h0);
         rd(`ETC_CYC_OFS);
         `CHK(rd_d, s[31:0])
         rd(`ETC_STAT_OFS);
         `CHK(rd_d[0], s[32])
      end
      // Clock enable low freezes the counter although cycles arrive.
      v = $urandom;
      wr(`ETC_CYC_OFS, v);
      wr(`ETC_CTRL_OFS, 32'h1);
      ce <= 1'b0;
      burst(8'd6);
      ce <= 1'b1;
      wr(`ETC_CTRL_OFS, 32'h0);
      rd(`ETC_CYC_OFS);
      `CHK(rd_d, v)
      // Overflow as a break, raised then cleared as an interrupt.
      wr(`ETC_STAT_OFS, 32'h3);
      wr(`ETC_MASK_OFS, 32'h1);
      wr(`ETC_CYC_OFS, 32'hffff_fffd);
      wr(`ETC_CTRL_OFS, 32'h3);
      burst(8'd5);
      `CHK(break_req, 1'b1)
      `CHK(irq, 1'b1)
      rd(`ETC_CYC_OFS);
      `CHK(rd_d, 32'h0)
      wr(`ETC_STAT_OFS, 32'h1);
      wr(`ETC_CTRL_OFS, 32'h0);
      rd(`ETC_STAT_OFS);
      `CHK(rd_d[0], 1'b0)
      `CHK(irq, 1'b0)
      `CHK(break_req, 1'b0)
      // Entries: each of the five port codes 0 to 4 chosen at least once.
      for (int i = 0; i < 5; i++) begin
         sb = 3'($urandom_range(4, 0));
         wr(`ETC_PSEL_OFS, {26'h0, sb, 3'(i)});
         hist.delete();
         wr(`ETC_CTRL_OFS, 32'h9);
         burst(8'd5);
         wr(`ETC_CTRL_OFS, 32'h0);
         rd(`ETC_TIDX_OFS);
         `CHK(rd_d, 32'd5)
         r = $urandom_range(4, 0);
         wr(`ETC_RIDX_OFS, 32'(r));
         rd(`ETC_RDAT0_OFS);
         e[31:0] = rd_d;
         rd(`ETC_RDAT1_OFS);
         e[63:32] = rd_d;
         rd(`ETC_RDAT2_OFS);
         e[95:64] = rd_d;
         `CHK(e[79:0], ent(hist[r], 3'(i), sb))
      end
      // A start command zeroes the index.
      wr(`ETC_CTRL_OFS, 32'h20);
      wr(`ETC_CTRL_OFS, 32'h0);
      rd(`ETC_TIDX_OFS);
      `CHK(rd_d, 32'h0)
      // Memory fills and wraps: flag, zero index, break, then clear.
      wr(`ETC_MASK_OFS, 32'h2);
      wr(`ETC_CTRL_OFS, 32'hd);
      burst(8'd16);
      `CHK(break_req, 1'b1)
      `CHK(irq, 1'b1)
      rd(`ETC_TIDX_OFS);
      `CHK(rd_d, 32'h0)
      rd(`ETC_STAT_OFS);
      `CHK(rd_d[1], 1'b1)
      wr(`ETC_CTRL_OFS, 32'h10);
      rd(`ETC_STAT_OFS);
      `CHK(rd_d[1], 1'b0)
      `CHK(irq, 1'b0)
      // Evaluation core reset request reaches the core once.
      rs = resets;
      wr(`ETC_CTRL_OFS, 32'h40);
      repeat (3) @(posedge clk);
      `CHK(resets, rs + 8'h01)
      close_out();
   end
endmodule : test_emulator_trace_cycle_counter
